// *** dv/cgo_clk_ctrl_tb.sv ***
/*
  self-checking bench for the clock gating and observe block.
  assumes the register port and pin mux behave as the hand-over
  note says; clock sources other than the system clock are held at static levels.
*/
module cgo_clk_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] q;} cgo_row_t;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic pll_on_in = 1'b1;
  logic stop_mode_in = 1'b0;
  logic [15:0] stop_keep_in = 16'h0000;
  logic [15:0] periph_sel_in = 16'hffff;
  logic [15:0] access_ok_out;
  logic [15:0] periph_clk_on_out;
  logic [15:0] seen;
  wire [3:0] fast;
  logic [3:0] pwm_in = 4'ha;
  logic [3:0] aux_clk = 4'b1101; // static levels: rosc, triple, double, periph
  logic [3:0] port_a_pins_out;
  logic port_b_function_select_in = 1'b1;
  logic port_b_pin_four_out;
  int err_total = 0;
  int comparisons = 0;
  // register table rows: written value and what must read back
  // rates change only with clocks off
  // peripherals see bus accesses while enabled, clocks then off
  cgo_row_t rows [8] = '{
    '{8'h0a, 16'hffff, 16'h03ff}, '{8'h0b, 16'hffff, 16'hf000},
    '{8'h0c, 16'hffff, 16'hf47d}, '{8'h0d, 16'hffff, 16'h0000},
    '{8'h0a, 16'h0000, 16'h0000}, '{8'h0c, 16'h0001, 16'h0001},
    '{8'h0c, 16'h0000, 16'h0000}, '{8'h0b, 16'ha000, 16'ha000}};
  cgo_clk_ctrl dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pll_on_in(pll_on_in), .stop_mode_in(stop_mode_in), .stop_keep_in(stop_keep_in),
    .periph_sel_in(periph_sel_in), .access_ok_out(access_ok_out),
    .periph_clk_on_out(periph_clk_on_out), .timer_b_fast_out(fast[3]),
    .timer_a_fast_out(fast[2]), .pwm_fast_out(fast[1]), .i2c_run_fast_out(fast[0]),
    .clk_periph_in(aux_clk[0]), .clk_2x_in(aux_clk[1]), .clk_3x_in(aux_clk[2]),
    .clk_rosc_in(aux_clk[3]),
    .pwm_in(pwm_in), .port_a_pins_out(port_a_pins_out),
    .port_b_function_select_in(port_b_function_select_in),
    .port_b_pin_four_out(port_b_pin_four_out));
  cgo_periph_model partner (.clk_in(clk_in), .nrst_in(nrst_in),
    .access_ok_in(access_ok_out), .seen_out(seen));
  // free running system clock
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rdchk
  // sample the pin mux while the system clock is low
  task automatic lo();
    @(posedge clk_in);
    #25;
  endtask : lo
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // hang guard
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    $display("mismatch at %0t: run too long", $time);
    end_sim();
  end
  initial begin
    logic [3:0] obs_exp;
    obs_exp = 4'b0110;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1 chk({12'h000, port_a_pins_out}, {12'h000, pwm_in});
    chk({15'h0000, port_b_pin_four_out}, 16'h0000);
    rdchk(cgo_pkg::OBS_SEL_ADDR, cgo_pkg::OBS_SEL_RST);
    @(posedge clk_in);
    #1 chk(rdata_out, 16'h0000);
    rdchk(cgo_pkg::RATE_ADDR, 16'h0000);
    rdchk(cgo_pkg::ENA_ADDR, 16'h0000);
    chk(seen, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].q);
    end
    // fast clock selects, then pll lost
    // all clocks off here
    wr(cgo_pkg::RATE_ADDR, 16'hf000);
    repeat (2) @(posedge clk_in);
    #1 chk({12'h000, fast}, 16'h000f);
    @(posedge clk_in);
    pll_on_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1 chk({12'h000, fast}, 16'h0000);
    @(posedge clk_in);
    pll_on_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    // clock gates, qualified bus access, stop with keep
    wr(cgo_pkg::ENA_ADDR, 16'hffff);
    repeat (2) @(posedge clk_in);
    #1 chk(periph_clk_on_out, 16'hf47d);
    chk(access_ok_out, 16'hf47d);
    chk(seen, 16'hf47d);
    @(posedge clk_in);
    stop_keep_in <= 16'h4001;
    stop_mode_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk(periph_clk_on_out, 16'h4001);
    chk(access_ok_out, 16'h4001);
    @(posedge clk_in);
    stop_mode_in <= 1'b0;
    // port a clocks: a3 osc, a2 sys (low now), a1 2x, a0 3x
    wr(cgo_pkg::OBS_SEL_ADDR, 16'h03c0);
    lo();
    chk({12'h000, port_a_pins_out}, 16'h0009);
    // high half: a2 now shows the system clock high
    @(posedge clk_in);
    #5 chk({12'h000, port_a_pins_out}, 16'h000d);
    // observe codes 0..3 sampled in the low half
    // no test codes programmed
    for (int c = 0; c < 4; c++) begin
      wr(cgo_pkg::OBS_SEL_ADDR, 16'h0000 | 16'(c));
      lo();
      chk({15'h0000, port_b_pin_four_out}, {15'h0000, obs_exp[c]});
    end
    // code 0 in the high half tells the system clock from off
    wr(cgo_pkg::OBS_SEL_ADDR, 16'h0000);
    @(posedge clk_in);
    #5 chk({15'h0000, port_b_pin_four_out}, 16'h0001);
    wr(cgo_pkg::OBS_SEL_ADDR, 16'h0021);
    lo();
    chk({15'h0000, port_b_pin_four_out}, 16'h0000);
    wr(cgo_pkg::OBS_SEL_ADDR, 16'h0001);
    port_b_function_select_in <= 1'b0;
    lo();
    chk({15'h0000, port_b_pin_four_out}, 16'h0000);
    // reset in mid-run brings every register back to its start value
    wr(cgo_pkg::OBS_SEL_ADDR, 16'h03c1);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1 chk(periph_clk_on_out, 16'h0000);
    chk({12'h000, fast}, 16'h0000);
    chk({12'h000, port_a_pins_out}, {12'h000, pwm_in});
    rdchk(cgo_pkg::OBS_SEL_ADDR, cgo_pkg::OBS_SEL_RST);
    rdchk(cgo_pkg::RATE_ADDR, cgo_pkg::RATE_RST);
    rdchk(cgo_pkg::ENA_ADDR, cgo_pkg::ENA_RST);
    end_sim();
  end
endmodule : cgo_clk_ctrl_tb

// *** dv/cgo_periph_model.sv ***
/*
  peripheral side model: remembers which peripherals ever took a
  bus access through the gate qualifier of the clock block.
  assumes it runs on the same system clock and reset.
*/
module cgo_periph_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [15:0] access_ok_in,
  output logic [15:0] seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // sticky record; a gated peripheral must never show up here
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      seen_out <= 16'h0000;
    end else begin
      seen_out <= seen_out | access_ok_in;
    end
  end
endmodule : cgo_periph_model

// *** hdl/cgo_clk_ctrl.sv ***
/*
  peripheral clock gating, rate select and clock observe control.
  holds three 16-bit registers on a plain register port and
  drives per-peripheral gate enables, fast-rate selects and the
  clock pins of port a and port b pin four.
  assumes the gate enables feed glitch-free clock gate cells in
  each peripheral, and that the stop request, stop-keep bits,
  port b function select and peripheral selects come from logic
  on the system clock. pll status arrives from another domain.
*/
// Our own choice: the address-and-strobe port.
module cgo_clk_ctrl (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic pll_on_in,
  input wire logic stop_mode_in,
  input wire logic [15:0] stop_keep_in,
  input wire logic [15:0] periph_sel_in,
  output logic [15:0] access_ok_out,
  output logic [15:0] periph_clk_on_out,
  output logic timer_b_fast_out,
  output logic timer_a_fast_out,
  output logic pwm_fast_out,
  output logic i2c_run_fast_out,
  input wire logic clk_periph_in,
  input wire logic clk_2x_in,
  input wire logic clk_3x_in,
  input wire logic clk_rosc_in,
  input wire logic [3:0] pwm_in,
  output logic [3:0] port_a_pins_out,
  input wire logic port_b_function_select_in,
  output logic port_b_pin_four_out
);

  // software visible registers, reserved bits held at zero
  logic [15:0] obs_sel_ff; // observe and port a select
  logic [15:0] rate_ff; // fast rate bits
  logic [15:0] ena_ff; // clock enable bits
  logic [15:0] rdata_ff; // read data, one cycle late
  logic [15:0] nxt_rdata;
  // gate enables after the stop override
  logic [15:0] clk_on_ff;
  logic [15:0] nxt_clk_on;
  // pll status synchroniser and filtered level
  logic pll_s1_ff;
  logic pll_s2_ff;
  logic pll_s3_ff;
  logic pll_ok_ff;
  // registered fast selects
  logic [3:0] fast_ff;
  logic [3:0] nxt_fast;
  // write decode
  logic wr_obs;
  logic wr_rate;
  logic wr_ena;

  // pin mux carrier
  cgo_obs_if obs_bus ();

  // address decode for the write strobes; the read mux decodes on its own
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_obs = wr_in & hit(addr_in, cgo_pkg::OBS_SEL_ADDR);
  assign wr_rate = wr_in & hit(addr_in, cgo_pkg::RATE_ADDR);
  assign wr_ena = wr_in & hit(addr_in, cgo_pkg::ENA_ADDR);

  // observe select register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      obs_sel_ff <= cgo_pkg::OBS_SEL_RST;
    end else if (wr_obs) begin
      obs_sel_ff <= wdata_in & cgo_pkg::OBS_SEL_MASK;
    end
  end

  // rate register; only the top four bits exist
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rate_ff <= cgo_pkg::RATE_RST;
    end else if (wr_rate) begin
      rate_ff <= wdata_in & cgo_pkg::RATE_MASK;
    end
  end

  // clock enable register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ena_ff <= cgo_pkg::ENA_RST;
    end else if (wr_ena) begin
      ena_ff <= wdata_in & cgo_pkg::ENA_MASK;
    end
  end

  // read mux: unmapped addresses and idle cycles return zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        cgo_pkg::OBS_SEL_ADDR: nxt_rdata = obs_sel_ff;
        cgo_pkg::RATE_ADDR: nxt_rdata = rate_ff;
        cgo_pkg::ENA_ADDR: nxt_rdata = ena_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;

  // pll status comes from the clock generator domain
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pll_s1_ff <= 1'b0;
      pll_s2_ff <= 1'b0;
      pll_s3_ff <= 1'b0;
    end else begin
      pll_s1_ff <= pll_on_in;
      pll_s2_ff <= pll_s1_ff;
      pll_s3_ff <= pll_s2_ff;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pll_ok_ff <= 1'b0;
    end else if (pll_s2_ff == pll_s3_ff) begin
      pll_ok_ff <= pll_s3_ff;
    end
  end

  // fast selects: a set bit without the pll falls back to the
  // system rate rather than starving the peripheral of a clock
  always_comb begin
    nxt_fast[3] = rate_ff[cgo_pkg::TMRB_RATE_BIT] & pll_ok_ff;
    nxt_fast[2] = rate_ff[cgo_pkg::TMRA_RATE_BIT] & pll_ok_ff;
    nxt_fast[1] = rate_ff[cgo_pkg::PWM_RATE_BIT] & pll_ok_ff;
    nxt_fast[0] = rate_ff[cgo_pkg::I2C_RATE_BIT] & pll_ok_ff;
  end

  // selects are registered so the clock mux cells see clean levels
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fast_ff <= 4'h0;
    end else begin
      fast_ff <= nxt_fast;
    end
  end

  assign timer_b_fast_out = fast_ff[3];
  assign timer_a_fast_out = fast_ff[2];
  assign pwm_fast_out = fast_ff[1];
  assign i2c_run_fast_out = fast_ff[0];

  // gate enables: enable bit, cleared in stop unless kept.
  // a set bit does not promise a running clock for this reason.
  always_comb begin
    nxt_clk_on = ena_ff & (~{16{stop_mode_in}} | stop_keep_in);
  end

  // enables are flops so the gate cells never see decode glitches
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      clk_on_ff <= 16'h0000;
    end else begin
      clk_on_ff <= nxt_clk_on;
    end
  end

  assign periph_clk_on_out = clk_on_ff;

  assign access_ok_out = periph_sel_in & clk_on_ff;

  // hand the select fields and clocks to the pin mux
  assign obs_bus.obs_off = obs_sel_ff[cgo_pkg::OBS_OFF_BIT];
  assign obs_bus.obs_src = obs_sel_ff[cgo_pkg::SRC_LSB +: 5];
  assign obs_bus.alt_sel = obs_sel_ff[cgo_pkg::ALT_SEL_LSB +: 4];
  assign obs_bus.pll_ok = pll_ok_ff;
  assign obs_bus.clk_sys = clk_in;
  assign obs_bus.clk_periph = clk_periph_in;
  assign obs_bus.clk_2x = clk_2x_in;
  assign obs_bus.clk_3x = clk_3x_in;
  assign obs_bus.clk_rosc = clk_rosc_in;
  assign obs_bus.pwm = pwm_in;

  // pin mux; test only, glitches on select change are accepted
  cgo_obs_mux u_mux (
    .bus(obs_bus.mux)
  );

  assign port_a_pins_out = obs_bus.pin_a;

  assign port_b_pin_four_out = port_b_function_select_in & obs_bus.obs_clk;

  // checks on the register side, fast selects, gate enables and pin mux
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_rd_obs_data: assert property (
    rd_in && addr_in == cgo_pkg::OBS_SEL_ADDR |=> rdata_out == $past(obs_sel_ff)
  ) else $error("observe select read data wrong");

  a_rate_rsvd_zero: assert property (
    rd_in && addr_in == cgo_pkg::RATE_ADDR |=> rdata_out[11:0] == 12'h000
  ) else $error("reserved rate bits read nonzero");

  a_obs_wr_mask: assert property (
    wr_obs |=> obs_sel_ff == ($past(wdata_in) & 16'h03ff)
  ) else $error("observe select write not masked");

  a_tmrb_fast_rate: assert property (
    (wr_rate && wdata_in[15]) ##1 pll_ok_ff |=> timer_b_fast_out
  ) else $error("timer b fast select not taken");

  a_fast_needs_pll: assert property (
    !pll_ok_ff |=> !timer_a_fast_out && !pwm_fast_out
  ) else $error("fast select without pll");

  a_stop_gates_off: assert property (
    stop_mode_in && !stop_keep_in[15] |=> !periph_clk_on_out[15]
  ) else $error("stop did not gate comparator clock");

  a_stop_keep_on: assert property (
    stop_mode_in && stop_keep_in[14] && ena_ff[14] |=> periph_clk_on_out[14]
  ) else $error("kept clock gated in stop");

  a_gate_blocks_access: assert property (
    !periph_clk_on_out[12] |-> !access_ok_out[12]
  ) else $error("access passed to gated peripheral");

  a_obs_off_low: assert property (
    obs_sel_ff[5] |-> !port_b_pin_four_out
  ) else $error("observe output active while off");

  a_obs_code3_low: assert property (
    obs_sel_ff[4:0] == 5'h03 |-> !port_b_pin_four_out
  ) else $error("undefined code drives observe");

  a_pin_a3_pwm: assert property (
    !obs_sel_ff[9] |-> port_a_pins_out[3] == pwm_in[3]
  ) else $error("pin a3 not carrying pwm");

  a_pin_a3_alt: assert property (
    obs_sel_ff[9] |-> port_a_pins_out[3] == clk_rosc_in
  ) else $error("pin a3 not carrying oscillator clock");

  a_pin_a2_pwm: assert property (
    !obs_sel_ff[8] |-> port_a_pins_out[2] == pwm_in[2]
  ) else $error("pin a2 not carrying pwm");

  a_pin_a1_alt: assert property (
    obs_sel_ff[7] |-> port_a_pins_out[1] == clk_2x_in
  ) else $error("pin a1 not carrying double clock");

  a_pin_a0_pwm: assert property (
    !obs_sel_ff[6] |-> port_a_pins_out[0] == pwm_in[0]
  ) else $error("pin a0 not carrying pwm");

  a_b4_needs_sel: assert property (
    !port_b_function_select_in |-> !port_b_pin_four_out
  ) else $error("pin b4 observes without function select");

  a_rd_rate_data: assert property (
    rd_in && addr_in == cgo_pkg::RATE_ADDR |=> rdata_out == $past(rate_ff)
  ) else $error("rate read data wrong");

  a_rd_ena_data: assert property (
    rd_in && addr_in == cgo_pkg::ENA_ADDR |=> rdata_out == $past(ena_ff)
  ) else $error("enable read data wrong");

  a_rd_idle_zero: assert property (
    !rd_in |=> rdata_out == 16'h0000
  ) else $error("read data outside read cycle");

  a_rate_wr_mask: assert property (
    wr_rate |=> rate_ff == ($past(wdata_in) & cgo_pkg::RATE_MASK)
  ) else $error("rate write not masked");

  a_ena_wr_mask: assert property (
    wr_ena |=> ena_ff == ($past(wdata_in) & cgo_pkg::ENA_MASK)
  ) else $error("enable write not masked");

  a_gate_follows_ena: assert property (
    !stop_mode_in |=> periph_clk_on_out == $past(ena_ff)
  ) else $error("gate enable does not follow enable bits");

  a_tmra_fast_rate: assert property (
    pll_ok_ff |=> timer_a_fast_out == $past(rate_ff[cgo_pkg::TMRA_RATE_BIT])
  ) else $error("timer a fast select wrong");

endmodule : cgo_clk_ctrl

// *** hdl/cgo_obs_if.sv ***
/*
  carrier between the register side and the clock pin mux.
  assumes both ends sit in the same top module.
*/
interface cgo_obs_if;
  logic obs_off; // observe output switched off
  logic [4:0] obs_src; // observe source code
  logic [3:0] alt_sel; // port a pins take clocks
  logic pll_ok; // triple rate clock exists
  logic clk_sys; // system clock
  logic clk_periph; // continuous peripheral clock
  logic clk_2x; // double rate clock
  logic clk_3x; // triple rate clock
  logic clk_rosc; // relaxation oscillator clock
  logic [3:0] pwm; // pwm channel outputs
  logic [3:0] pin_a; // port a peripheral outputs
  logic obs_clk; // observed clock
  modport ctrl(
    output obs_off, obs_src, alt_sel, pll_ok, clk_sys, clk_periph,
    output clk_2x, clk_3x, clk_rosc, pwm,
    input pin_a, obs_clk
  );
  modport mux(
    input obs_off, obs_src, alt_sel, pll_ok, clk_sys, clk_periph,
    input clk_2x, clk_3x, clk_rosc, pwm,
    output pin_a, obs_clk
  );
endinterface : cgo_obs_if

// *** hdl/cgo_obs_mux.sv ***
/*
  combinational clock pin mux for port a and the observe output.
  assumes selects come from flops on the system clock; the
  outputs are test clocks and may glitch on a select change.
*/
module cgo_obs_mux (
  cgo_obs_if.mux bus
);
  // port a: pwm channel or an internal clock per pin
  always_comb begin
    bus.pin_a[3] = bus.alt_sel[3] ? bus.clk_rosc : bus.pwm[3];
    bus.pin_a[2] = bus.alt_sel[2] ? bus.clk_sys : bus.pwm[2];
    bus.pin_a[1] = bus.alt_sel[1] ? bus.clk_2x : bus.pwm[1];
    bus.pin_a[0] = bus.alt_sel[0] ? (bus.clk_3x & bus.pll_ok) : bus.pwm[0];
  end

  // observe source: unknown and test codes hold the output low
  always_comb begin
    bus.obs_clk = 1'b0;
    if (!bus.obs_off) begin
      case (bus.obs_src)
        cgo_pkg::SRC_SYS: bus.obs_clk = bus.clk_sys;
        cgo_pkg::SRC_PERIPH: bus.obs_clk = bus.clk_periph;
        cgo_pkg::SRC_TRIPLE: bus.obs_clk = bus.clk_3x & bus.pll_ok;
        default: bus.obs_clk = 1'b0;
      endcase
    end
  end
endmodule : cgo_obs_mux

// *** hdl/cgo_pkg.sv ***
/*
  constants for the peripheral clock gating and observe block:
  register offsets, write masks, reset values, field positions
  and observe source codes.
  assumes a 16-bit register port addressed by word index.
*/
package cgo_pkg;
  // register index on the plain register port
  localparam logic [7:0] OBS_SEL_ADDR = 8'h0a;
  localparam logic [7:0] RATE_ADDR = 8'h0b;
  localparam logic [7:0] ENA_ADDR = 8'h0c;
  // values after reset; observe starts switched off
  localparam logic [15:0] OBS_SEL_RST = 16'h0020;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] ENA_RST = 16'h0000;
  // writable bits; everything else is reserved and reads zero
  localparam logic [15:0] OBS_SEL_MASK = 16'h03ff;
  localparam logic [15:0] RATE_MASK = 16'hf000;
  localparam logic [15:0] ENA_MASK = 16'hf47d;
  // observe select fields
  localparam int OBS_OFF_BIT = 5;
  localparam int ALT_SEL_LSB = 6;
  localparam int SRC_LSB = 0;
  // rate register fields
  localparam int TMRB_RATE_BIT = 15;
  localparam int TMRA_RATE_BIT = 14;
  localparam int PWM_RATE_BIT = 13;
  localparam int I2C_RATE_BIT = 12;
  // enable register fields
  localparam int COMPARATOR_B_CLOCK_ON_ON_BIT = 15;
  localparam int COMPARATOR_A_CLOCK_ON_ON_BIT = 14;
  localparam int CONVERTER_OUT_ONE_CLOCK_ON_ON_BIT = 13;
  localparam int CONVERTER_OUT_ZERO_CLOCK_ON_ON_BIT = 12;
  localparam int ADC_ON_BIT = 10;
  // observe source codes
  localparam logic [4:0] SRC_SYS = 5'h00;
  localparam logic [4:0] SRC_PERIPH = 5'h01;
  localparam logic [4:0] SRC_TRIPLE = 5'h02;
endpackage : cgo_pkg
